// ===== core/gia_byte_mux.v
// Picks one byte of a big-endian 32-bit word by its address low bits.
// Assumes byte 0 is the most significant byte.
`timescale 1ns/1ps
module gia_byte_mux
(
    // Word and lane select
    input  wire [31:0] word,
    input  wire [1:0]  lane,
    // Selected byte
    output reg  [7:0]  byte_out
);
    always @*
    begin
        case (lane)
            2'h0:    byte_out = word[31:24];
            2'h1:    byte_out = word[23:16];
            2'h2:    byte_out = word[15:8];
            default: byte_out = word[7:0];
        endcase
    end
endmodule

// ===== core/gia_consts.vh
// Offsets, field positions and reset values of the global control block.
// Assumes byte addressing with big-endian order inside multi-byte registers.
`ifndef GIA_CONSTS_VH
`define GIA_CONSTS_VH
`define GIA_ADDR_W          16
`define GIA_OFS_ID_LOW      16'h0002
`define GIA_OFS_REV_RST     16'h0003
`define GIA_OFS_PWR_CTL     16'h0006
`define GIA_OFS_GSTAT       16'h0010
`define GIA_OFS_GMASK       16'h0014
`define GIA_OFS_PSTAT       16'h0018
`define GIA_OFS_PMASK       16'h001C
`define GIA_BIT_SOFT_RST    0
`define GIA_BIT_PWR_OE      1
`define GIA_BIT_PWR_POL     0
`define GIA_BIT_LOOKUP      31
`define GIA_BIT_GPIO        30
`define GIA_NUM_PORTS       7
`define GIA_RST_CTL         8'h00
`define GIA_RST_MASK        2'h0
`define GIA_RST_PMASK       7'h00
`endif

// ===== core/gia_sync_bit.v
// Registered copy of one interrupt source level.
// Assumes the source is synchronous to clk.
`timescale 1ns/1ps
module gia_sync_bit
(
    // Clock and reset
    input  wire clk,
    input  wire rst,
    // Source and registered status
    input  wire src,
    output reg  stat_r
);
    always @(posedge clk)
    begin
        if (rst)
            stat_r <= 1'b0;
        else
            stat_r <= src;
    end
endmodule

// ===== core/gia_top.v
// Global identity, soft reset, power-event pin and interrupt aggregation.
// Assumes a byte-wide management port synchronous to clk, one access per strobe.
//
// Summary of operation
// RL1: Soft reset bit holds until software clears
// RL2: Soft reset holds datapath, keeps configuration
// RL3: Power-event pin driven only when enabled
// RL4: Polarity bit zero means active low
// RL5: Lookup engine pending shows in bit 31
// RL6: GPIO/timestamp pending shows in bit 30
// RL7: Global mask one disables that source
// RL8: Port n request shows in bit n-1
// RL9: Port mask one blocks that port
// RL10: Masks and status zero after reset
// RL11: Request is OR of unmasked status
// RL12: Reserved bits ignore writes, read zero
`timescale 1ns/1ps
`include "gia_consts.vh"
module gia_top
#(
    parameter [7:0] CHIP_ID_LOW = 8'h5A,   // Arbitrary identity value
    parameter [3:0] REVISION    = 4'h1,    // Arbitrary revision value
    parameter       NPORTS      = `GIA_NUM_PORTS
)
(
    // Clock and reset
    input  wire              clk,
    input  wire              rst,
    // Management byte port
    input  wire [15:0]       mg_addr,
    input  wire              mg_wr,
    input  wire              mg_rd,
    input  wire [7:0]        mg_wdata,
    output reg  [7:0]        mg_rdata_r,
    output reg               mg_rvalid_r,
    // Interrupt sources
    input  wire              lookup_engine_irq,
    input  wire              gpio_ts_irq,
    input  wire [NPORTS-1:0] port_irq,
    // Power-event event request
    input  wire              power_event_req,
    // Outputs
    output reg               dp_reset_r,
    output reg               irq_r,
    output reg               power_event_output_o_r,
    output reg               power_event_output_oe_r
);
    reg              soft_rst_r;
    reg              pwr_oe_r;
    reg              pwr_pol_r;
    reg  [1:0]       gmask_r;
    reg  [NPORTS-1:0] pmask_r;
    wire             lue_stat;
    wire             gpio_stat;
    wire [NPORTS-1:0] pstat;
    wire [31:0]      gstat_w;
    wire [31:0]      gmask_w;
    wire [31:0]      pstat_w;
    wire [31:0]      pmask_w;
    wire [7:0]       b_gstat;
    wire [7:0]       b_gmask;
    wire [7:0]       b_pstat;
    wire [7:0]       b_pmask;
    reg  [7:0]       rd_nxt;
    wire             irq_nxt;
    wire             wr_word;
    wire [1:0]       lane;

    // Status follows each source; zero under reset
    gia_sync_bit u_lue
    (
        .clk    (clk),
        .rst    (rst),
        .src    (lookup_engine_irq),
        .stat_r (lue_stat)
    ); // RL5 RL10 RL11
    gia_sync_bit u_gpio
    (
        .clk    (clk),
        .rst    (rst),
        .src    (gpio_ts_irq),
        .stat_r (gpio_stat)
    ); // RL6 RL10 RL11
    genvar gi;
    generate
        for (gi = 0; gi < NPORTS; gi = gi + 1)
        begin : g_port
            gia_sync_bit u_p
            (
                .clk    (clk),
                .rst    (rst),
                .src    (port_irq[gi]),
                .stat_r (pstat[gi])
            ); // RL8
        end
    endgenerate

    // Word images, reserved bits zero
    assign gstat_w = {lue_stat, gpio_stat, 30'h0000_0000}; // RL5 RL6 RL12
    assign gmask_w = {gmask_r, 30'h0000_0000}; // RL12
    assign pstat_w = {{(32-NPORTS){1'b0}}, pstat}; // RL8 RL12
    assign pmask_w = {{(32-NPORTS){1'b0}}, pmask_r}; // RL12
    assign lane    = mg_addr[1:0];
    assign wr_word = mg_wr;

    gia_byte_mux u_bm0 (.word(gstat_w), .lane(lane), .byte_out(b_gstat));
    gia_byte_mux u_bm1 (.word(gmask_w), .lane(lane), .byte_out(b_gmask));
    gia_byte_mux u_bm2 (.word(pstat_w), .lane(lane), .byte_out(b_pstat));
    gia_byte_mux u_bm3 (.word(pmask_w), .lane(lane), .byte_out(b_pmask));

    // Read decode
    always @*
    begin
        case ({mg_addr[15:2], 2'b00})
            `GIA_OFS_GSTAT: rd_nxt = b_gstat;
            `GIA_OFS_GMASK: rd_nxt = b_gmask;
            `GIA_OFS_PSTAT: rd_nxt = b_pstat;
            `GIA_OFS_PMASK: rd_nxt = b_pmask;
            16'h0000:
            begin
                if (mg_addr == `GIA_OFS_ID_LOW)
                    rd_nxt = CHIP_ID_LOW;
                else if (mg_addr == `GIA_OFS_REV_RST)
                    rd_nxt = {REVISION, 3'b000, soft_rst_r}; // RL12
                else
                    rd_nxt = 8'h00;
            end
            16'h0004:
            begin
                if (mg_addr == `GIA_OFS_PWR_CTL)
                    rd_nxt = {6'h00, pwr_oe_r, pwr_pol_r}; // RL12
                else
                    rd_nxt = 8'h00;
            end
            default: rd_nxt = 8'h00;
        endcase
    end

    // Configuration writes; only the system reset touches these
    always @(posedge clk)
    begin
        if (rst)
        begin
            soft_rst_r <= 1'b0;
            pwr_oe_r   <= 1'b0; // RL3
            pwr_pol_r  <= 1'b0; // RL4
            gmask_r    <= `GIA_RST_MASK; // RL10
            pmask_r    <= {NPORTS{1'b0}}; // RL10
        end
        else if (wr_word)
        begin
            case (mg_addr)
                `GIA_OFS_REV_RST: soft_rst_r <= mg_wdata[`GIA_BIT_SOFT_RST]; // RL1
                `GIA_OFS_PWR_CTL:
                begin
                    pwr_oe_r  <= mg_wdata[`GIA_BIT_PWR_OE];
                    pwr_pol_r <= mg_wdata[`GIA_BIT_PWR_POL];
                end
                `GIA_OFS_GMASK: gmask_r <= mg_wdata[7:6]; // RL7
                `GIA_OFS_PMASK + 16'h0003: pmask_r <= mg_wdata[NPORTS-1:0]; // RL9
                default: ;
            endcase
        end
    end

    assign irq_nxt = (lue_stat & ~gmask_r[1]) | (gpio_stat & ~gmask_r[0]) |
                     (|(pstat & ~pmask_r)); // RL7 RL9 RL11

    // Registered outputs
    always @(posedge clk)
    begin
        if (rst)
        begin
            mg_rdata_r              <= 8'h00;
            mg_rvalid_r             <= 1'b0;
            dp_reset_r              <= 1'b1;
            irq_r                   <= 1'b0;
            power_event_output_o_r  <= 1'b0;
            power_event_output_oe_r <= 1'b0;
        end
        else
        begin
            mg_rdata_r              <= mg_rd ? rd_nxt : mg_rdata_r;
            mg_rvalid_r             <= mg_rd;
            dp_reset_r              <= soft_rst_r; // RL2
            irq_r                   <= irq_nxt; // RL11
            power_event_output_o_r  <= pwr_pol_r ? power_event_req : ~power_event_req; // RL4
            power_event_output_oe_r <= pwr_oe_r; // RL3
        end
    end
endmodule

// ===== tb/gia_props.sv
// Port checker for gia_top.
// Assumes byte accesses; shadows the control bits from writes.
`timescale 1ns/1ps
module gia_props
#(
    parameter NPORTS = 7
)
(
    // Clock and reset
    input wire              clk,
    input wire              rst,
    // Management port
    input wire [15:0]       mg_addr,
    input wire              mg_wr,
    input wire              mg_rd,
    input wire [7:0]        mg_wdata,
    input wire [7:0]        mg_rdata_r,
    // Sources and outputs
    input wire              lookup_engine_irq,
    input wire              gpio_ts_irq,
    input wire [NPORTS-1:0] port_irq,
    input wire              power_event_req,
    input wire              dp_reset_r,
    input wire              irq_r,
    input wire              power_event_output_o_r,
    input wire              power_event_output_oe_r
);
    reg              sr_m, oe_m, pl_m;
    reg [1:0]        gm_m;
    reg [NPORTS-1:0] pm_m;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    always @(posedge clk)
        if (rst)
            {sr_m, oe_m, pl_m, gm_m, pm_m} <= '0;
        else if (mg_wr)
            case (mg_addr)
            16'h0003: sr_m <= mg_wdata[0];
            16'h0006: {oe_m, pl_m} <= mg_wdata[1:0];
            16'h0014: gm_m <= mg_wdata[7:6];
            16'h001F: pm_m <= mg_wdata[NPORTS-1:0];
            default: ;
            endcase
    soft_rst_a: assert property (!$past(rst) |-> dp_reset_r == $past(sr_m))
        else $error("datapath reset wrong");
    pin_oe_a: assert property (!$past(rst) |-> power_event_output_oe_r == $past(oe_m))
        else $error("pin enable wrong");
    pin_pol_a: assert property (power_event_output_oe_r |->
        power_event_output_o_r == ($past(power_event_req) ~^ $past(pl_m)))
        else $error("pin level wrong");
    irq_or_a: assert property (!$past(rst) && !$past(rst, 2) |-> irq_r ==
        (|({$past(lookup_engine_irq, 2), $past(gpio_ts_irq, 2)} & ~$past(gm_m))
        || |($past(port_irq, 2) & ~$past(pm_m))))
        else $error("irq wrong");
    gstat_rd_a: assert property (mg_rd && !$past(rst) && mg_addr == 16'h0010 |=>
        mg_rdata_r == {$past(lookup_engine_irq, 2), $past(gpio_ts_irq, 2), 6'h00})
        else $error("global status wrong");
    pstat_rd_a: assert property (mg_rd && !$past(rst) && mg_addr == 16'h001B |=>
        mg_rdata_r == {1'b0, $past(port_irq, 2)})
        else $error("port status wrong");
    gmask_rd_a: assert property (mg_rd && mg_addr == 16'h0014 |=>
        mg_rdata_r == {$past(gm_m), 6'h00})
        else $error("global mask wrong");
    pmask_rd_a: assert property (mg_rd && mg_addr == 16'h001F |=>
        mg_rdata_r == {1'b0, $past(pm_m)})
        else $error("port mask wrong");
endmodule

// ===== tb/tb_top.sv
// Self-checking bench for gia_top.
// Assumes the byte management port and one 20 MHz clock.
`timescale 1ns/1ps
module tb_top;
    reg         clk = 1'b0;
    reg         rst = 1'b1;
    reg  [15:0] a = 16'h0000;
    reg         wr = 1'b0, rdq = 1'b0, lookup_engine = 1'b0, gts = 1'b0, req = 1'b0;
    reg  [7:0]  wd = 8'h00;
    reg  [6:0]  pi = 7'h00;
    wire [7:0]  rd;
    wire        rv, dpr, irq, po, poe;
    integer     n_mismatch = 0, comparisons = 0, i;
    always #25 clk = ~clk;
    gia_top uut (.clk(clk), .rst(rst), .mg_addr(a), .mg_wr(wr), .mg_rd(rdq),
        .mg_wdata(wd), .mg_rdata_r(rd), .mg_rvalid_r(rv), .lookup_engine_irq(lookup_engine),
        .gpio_ts_irq(gts), .port_irq(pi), .power_event_req(req), .dp_reset_r(dpr),
        .irq_r(irq), .power_event_output_o_r(po), .power_event_output_oe_r(poe));
    task chk(input [7:0] g, input [7:0] e);
        comparisons = comparisons + 1;
        if (g !== e)
        begin
            n_mismatch = n_mismatch + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task cyc(input integer n);
        repeat (n) @(negedge clk);
    endtask
    task wrb(input [15:0] ad, input [7:0] d);
        cyc(1);
        a = ad;
        wd = d;
        wr = 1'b1;
        cyc(1);
        wr = 1'b0;
    endtask
    task rdb(input [15:0] ad, input [7:0] e);
        cyc(1);
        a = ad;
        rdq = 1'b1;
        cyc(1);
        rdq = 1'b0;
        chk({7'h00, rv}, 8'h01);
        chk(rd, e);
    endtask
    task finish_test;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        #100000;
        n_mismatch = n_mismatch + 1;
        finish_test;
    end
    initial
    begin
        cyc(3);
        rst = 1'b0;
        cyc(2);
        chk({dpr, irq, poe}, 8'h00);
        wrb(16'h0002, 8'hFF);
        rdb(16'h0002, 8'h5A);
        for (i = 16; i < 32; i = i + 1)
            rdb(i[15:0], 8'h00);
        wrb(16'h0003, 8'hFF);
        cyc(8);
        rdb(16'h0003, 8'h11);
        chk({7'h00, dpr}, 8'h01);
        wrb(16'h0014, 8'hFF);
        wrb(16'h001F, 8'hFF);
        wrb(16'h0003, 8'h00);
        rdb(16'h0014, 8'hC0);
        rdb(16'h001F, 8'h7F);
        chk({7'h00, dpr}, 8'h00);
        for (i = 0; i < 9; i = i + 1)
        begin
            {lookup_engine, gts, pi} = 9'h100 >> i;
            wrb(16'h0014, {lookup_engine, gts, 6'h00});
            wrb(16'h001F, {1'b0, pi});
            cyc(2);
            chk({7'h00, irq}, 8'h00);
            rdb(16'h0010, {lookup_engine, gts, 6'h00});
            rdb(16'h001B, {1'b0, pi});
            wrb(16'h0014, 8'h00);
            wrb(16'h001F, 8'h00);
            cyc(2);
            chk({7'h00, irq}, 8'h01);
        end
        {lookup_engine, gts, pi} = 9'h000;
        cyc(3);
        chk({7'h00, irq}, 8'h00);
        wrb(16'h0006, 8'h02);
        for (i = 0; i < 4; i = i + 1)
        begin
            if (i == 2)
                wrb(16'h0006, 8'h03);
            req = i[0];
            cyc(2);
            chk({poe, po}, {7'h01, i[0] ~^ i[1]});
        end
        wrb(16'h0006, 8'h00);
        cyc(2);
        chk({7'h00, poe}, 8'h00);
        finish_test;
    end
endmodule
bind gia_top gia_props #(.NPORTS(NPORTS)) u_props (.clk(clk), .rst(rst),
    .mg_addr(mg_addr), .mg_wr(mg_wr), .mg_rd(mg_rd), .mg_wdata(mg_wdata),
    .mg_rdata_r(mg_rdata_r), .lookup_engine_irq(lookup_engine_irq),
    .gpio_ts_irq(gpio_ts_irq), .port_irq(port_irq), .power_event_req(power_event_req),
    .dp_reset_r(dp_reset_r), .irq_r(irq_r), .power_event_output_o_r(power_event_output_o_r),
    .power_event_output_oe_r(power_event_output_oe_r));
